// file: design/pllc_out_div.sv
// One output clock divider with phase offset and output gate
`timescale 1ns/1ns
module pllc_out_div (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Control
    input  wire logic       div_rst,
    input  wire logic       run,
    input  wire logic       gate,
    input  wire logic [7:0] divide,
    input  wire logic [7:0] phase,
    // Output clock
    output logic            clk_out
);

    logic [7:0] cnt_r;
    logic       tgl_r;
    logic       out_r;

    // ------------------------------------------------------------------
    // Divider, phase offset loaded on reset
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || div_rst || !run) begin
            cnt_r <= phase;
            tgl_r <= 1'b0;
        end else if (cnt_r >= divide) begin
            cnt_r <= pllc_pkg::RST_ZERO;
            tgl_r <= ~tgl_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Output gate
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            out_r <= 1'b0;
        end else begin
            out_r <= tgl_r & gate & run;
        end
    end

    assign clk_out = out_r;

    property p_gate_off;
        @(posedge clock) disable iff (srst) !gate |=> !clk_out;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("output runs while gated");

    property p_div_rst;
        @(posedge clock) disable iff (srst) div_rst |=> !tgl_r && cnt_r == $past(phase) ##1 !clk_out;
    endproperty
    a_div_rst: assert property (p_div_rst) else $error("divider reset ignored");

endmodule

// file: design/pllc_pkg.sv
// Constants and types shared by the loop control and configuration port
package pllc_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int CLK_HZ   = 20_000_000;
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 8;
    localparam int NUM_OUT  = 4;
    localparam int NUM_REGS = 32;

    // ------------------------------------------------------------------
    // Configuration register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_DIV_BASE = 5'h00;
    localparam logic [4:0] REG_PH_BASE  = 5'h04;
    localparam logic [4:0] REG_M_DIV    = 5'h08;
    localparam logic [4:0] REG_PH_SRC   = 5'h09;
    localparam int         SRC_BIT      = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DIV  = 8'h03;
    localparam logic [7:0] RST_PH   = 8'h00;
    localparam logic [7:0] RST_M    = 8'h03;
    localparam logic [7:0] RST_SRC  = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Feedback wraps needed before lock is declared
    localparam logic [7:0] LOCK_EDGES = 8'h08;

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } pllc_bus_t;

    typedef enum logic [2:0] {
        LOOP_DOWN   = 3'b001,
        LOOP_ACQ    = 3'b010,
        LOOP_LOCKED = 3'b100
    } pllc_loop_t;

endpackage

// file: design/pllc_top.sv
// Loop control boundary and configuration data bus port
`timescale 1ns/1ns
module pllc_top (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Loop control
    input  wire logic       loop_reset,
    input  wire logic       full_loop_reset,
    input  wire logic       out_b_divider_reset,
    input  wire logic       out_c_divider_reset,
    input  wire logic       power_down_req,
    // Output gates
    input  wire logic       primary_out_gate,
    input  wire logic       out_a_gate,
    input  wire logic       out_b_gate,
    input  wire logic       out_c_gate,
    // Output clocks and status
    output logic            primary_out_clk,
    output logic            secondary_out_clk_a,
    output logic            secondary_out_clk_b,
    output logic            secondary_out_clk_c,
    output logic            loop_locked,
    output logic            phase_ctrl_source_flag,
    // Configuration bus
    input  wire logic       cfg_bus_reset,
    input  wire logic       cfg_bus_strobe,
    input  wire logic       cfg_bus_write_en,
    input  wire logic [4:0] cfg_bus_addr,
    input  wire logic [7:0] cfg_bus_wdata,
    output logic      [7:0] cfg_bus_rdata,
    output logic            cfg_bus_ack
);

    logic [7:0]          regs_r [0:pllc_pkg::NUM_REGS-1];
    pllc_pkg::pllc_bus_t bus_st_r;
    pllc_pkg::pllc_loop_t loop_st_r;
    logic                ack_r;
    logic [7:0]          rdata_r;
    logic                src_r;
    logic                lock_r;
    logic [7:0]          m_cnt_r;
    logic [7:0]          lock_cnt_r;
    logic                accept;
    logic                fb_wrap;
    logic                run;
    logic [3:0]          gate_w;
    logic [3:0]          drst_w;
    logic [3:0]          clk_w;

    function automatic logic [7:0] reg_default(input int idx);
        logic [4:0] a;
        a = idx[4:0];
        if (a < pllc_pkg::REG_PH_BASE) begin
            reg_default = pllc_pkg::RST_DIV;
        end else if (a < pllc_pkg::REG_M_DIV) begin
            reg_default = pllc_pkg::RST_PH;
        end else if (a == pllc_pkg::REG_M_DIV) begin
            reg_default = pllc_pkg::RST_M;
        end else if (a == pllc_pkg::REG_PH_SRC) begin
            reg_default = pllc_pkg::RST_SRC;
        end else begin
            reg_default = pllc_pkg::RST_ZERO;
        end
    endfunction

    // ------------------------------------------------------------------
    // Configuration bus
    // ------------------------------------------------------------------
    assign accept = (bus_st_r == pllc_pkg::BUS_IDLE) && cfg_bus_strobe && !cfg_bus_reset;

    always_ff @(posedge clock) begin
        if (srst || cfg_bus_reset) begin
            bus_st_r <= pllc_pkg::BUS_IDLE;
            ack_r    <= 1'b0;
            rdata_r  <= pllc_pkg::RST_ZERO;
        end else begin
            case (bus_st_r)
                pllc_pkg::BUS_IDLE: begin
                    if (accept) begin
                        bus_st_r <= pllc_pkg::BUS_ACK;
                        ack_r    <= 1'b1;
                        rdata_r  <= regs_r[cfg_bus_addr];
                    end
                end
                pllc_pkg::BUS_ACK: begin
                    bus_st_r <= pllc_pkg::BUS_IDLE;
                    ack_r    <= 1'b0;
                end
                default: begin
                    bus_st_r <= pllc_pkg::BUS_IDLE;
                    ack_r    <= 1'b0;
                end
            endcase
        end
    end

    // Settings survive bus reset; only the block reset restores them
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < pllc_pkg::NUM_REGS; i++) begin
                regs_r[i] <= reg_default(i);
            end
        end else if (accept && cfg_bus_write_en) begin
            regs_r[cfg_bus_addr] <= cfg_bus_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            src_r <= 1'b0;
        end else begin
            src_r <= regs_r[pllc_pkg::REG_PH_SRC][pllc_pkg::SRC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Feedback divider
    // ------------------------------------------------------------------
    assign fb_wrap = (loop_st_r != pllc_pkg::LOOP_DOWN) && (m_cnt_r >= regs_r[pllc_pkg::REG_M_DIV]);

    always_ff @(posedge clock) begin
        if (srst || full_loop_reset) begin
            m_cnt_r <= pllc_pkg::RST_ZERO;
        end else if (loop_st_r == pllc_pkg::LOOP_DOWN) begin
            m_cnt_r <= m_cnt_r;
        end else if (fb_wrap) begin
            m_cnt_r <= pllc_pkg::RST_ZERO;
        end else begin
            m_cnt_r <= m_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Loop state and lock
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            loop_st_r  <= pllc_pkg::LOOP_ACQ;
            lock_cnt_r <= pllc_pkg::RST_ZERO;
        end else if (power_down_req) begin
            loop_st_r  <= pllc_pkg::LOOP_DOWN;
            lock_cnt_r <= pllc_pkg::RST_ZERO;
        end else if (loop_reset || full_loop_reset) begin
            loop_st_r  <= pllc_pkg::LOOP_ACQ;
            lock_cnt_r <= pllc_pkg::RST_ZERO;
        end else begin
            case (loop_st_r)
                pllc_pkg::LOOP_DOWN: begin
                    loop_st_r <= pllc_pkg::LOOP_ACQ;
                end
                pllc_pkg::LOOP_ACQ: begin
                    if (fb_wrap) begin
                        lock_cnt_r <= lock_cnt_r + 8'h01;
                        if (lock_cnt_r == pllc_pkg::LOCK_EDGES - 8'h01) begin
                            loop_st_r <= pllc_pkg::LOOP_LOCKED;
                        end
                    end
                end
                pllc_pkg::LOOP_LOCKED: begin
                    loop_st_r <= pllc_pkg::LOOP_LOCKED;
                end
                default: begin
                    loop_st_r <= pllc_pkg::LOOP_ACQ;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= (loop_st_r == pllc_pkg::LOOP_LOCKED);
        end
    end

    // ------------------------------------------------------------------
    // Output dividers
    // ------------------------------------------------------------------
    assign run    = (loop_st_r == pllc_pkg::LOOP_LOCKED);
    assign gate_w = {out_c_gate, out_b_gate, out_a_gate, primary_out_gate};
    assign drst_w = {out_c_divider_reset, out_b_divider_reset, 2'b00};

    for (genvar g = 0; g < pllc_pkg::NUM_OUT; g++) begin : g_out
        pllc_out_div u_div (
            .clock   (clock),
            .srst    (srst),
            .div_rst (drst_w[g]),
            .run     (run),
            .gate    (gate_w[g]),
            .divide  (regs_r[pllc_pkg::REG_DIV_BASE + 5'(g)]),
            .phase   (regs_r[pllc_pkg::REG_PH_BASE + 5'(g)]),
            .clk_out (clk_w[g])
        );
    end

    assign primary_out_clk        = clk_w[0];
    assign secondary_out_clk_a    = clk_w[1];
    assign secondary_out_clk_b    = clk_w[2];
    assign secondary_out_clk_c    = clk_w[3];
    assign loop_locked            = lock_r;
    assign phase_ctrl_source_flag = src_r;
    assign cfg_bus_rdata          = rdata_r;
    assign cfg_bus_ack            = ack_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_req;
        (bus_st_r == pllc_pkg::BUS_IDLE) && cfg_bus_strobe && !cfg_bus_reset;
    endsequence

    property p_ack_after;
        @(posedge clock) disable iff (srst || cfg_bus_reset) s_req |=> cfg_bus_ack;
    endproperty
    a_ack_after: assert property (p_ack_after) else $error("strobe not acknowledged");

    property p_ack_one;
        @(posedge clock) disable iff (srst) cfg_bus_ack |=> !cfg_bus_ack;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("acknowledge longer than one cycle");

    property p_rdata;
        logic [7:0] v;
        @(posedge clock) disable iff (srst || cfg_bus_reset)
            (s_req, v = regs_r[cfg_bus_addr]) |=> cfg_bus_ack && cfg_bus_rdata == v;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong at acknowledge");

    property p_bus_rst_keep;
        @(posedge clock) disable iff (srst)
            cfg_bus_reset |=> !cfg_bus_ack && $stable(regs_r[pllc_pkg::REG_M_DIV]);
    endproperty
    a_bus_rst_keep: assert property (p_bus_rst_keep) else $error("bus reset touched settings");

    property p_lock_cause;
        @(posedge clock) disable iff (srst)
            loop_locked |-> !$past(power_down_req, 2) && !$past(loop_reset, 2);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock while reset or down");

    property p_rst_keeps_m;
        @(posedge clock) disable iff (srst)
            (loop_reset && !full_loop_reset && !power_down_req &&
             loop_st_r != pllc_pkg::LOOP_DOWN && m_cnt_r < regs_r[pllc_pkg::REG_M_DIV])
            |=> m_cnt_r == $past(m_cnt_r) + 8'h01;
    endproperty
    a_rst_keeps_m: assert property (p_rst_keeps_m) else $error("loop reset cleared feedback");

    property p_full;
        @(posedge clock) disable iff (srst) full_loop_reset |=> m_cnt_r == 8'h00 ##1 !loop_locked;
    endproperty
    a_full: assert property (p_full) else $error("full reset missed divider");

    property p_pd;
        @(posedge clock) disable iff (srst)
            power_down_req |=> loop_st_r == pllc_pkg::LOOP_DOWN ##1 !loop_locked && !primary_out_clk;
    endproperty
    a_pd: assert property (p_pd) else $error("power down ignored");

    property p_src;
        @(posedge clock) disable iff (srst)
            (s_req and (cfg_bus_write_en && cfg_bus_addr == pllc_pkg::REG_PH_SRC))
            |=> ##1 phase_ctrl_source_flag == $past(cfg_bus_wdata[pllc_pkg::SRC_BIT], 2);
    endproperty
    a_src: assert property (p_src) else $error("phase source flag stale");

endmodule

// file: dv/pllc_fabric.sv
// Fabric-side master model for the configuration bus
`timescale 1ns/1ns
module pllc_fabric (
    // Clock
    input  wire logic       clock,
    // Request to block
    output logic            cfg_bus_strobe,
    output logic            cfg_bus_write_en,
    output logic      [4:0] cfg_bus_addr,
    output logic      [7:0] cfg_bus_wdata,
    // Answer from block
    input  wire logic       cfg_bus_ack,
    input  wire logic [7:0] cfg_bus_rdata
);
    initial begin
        cfg_bus_strobe   = 1'b0;
        cfg_bus_write_en = 1'b0;
        cfg_bus_addr     = 5'h00;
        cfg_bus_wdata    = 8'h00;
    end

    // One transfer after gap + 1 idle cycles; got tells whether ack came
    task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d,
                        input int gap, output logic [7:0] rd, output logic got);
        int n;
        got = 1'b0;
        rd  = 8'h00;
        repeat (gap + 1) @(negedge clock);
        cfg_bus_strobe   = 1'b1;
        cfg_bus_write_en = we;
        cfg_bus_addr     = a;
        cfg_bus_wdata    = d;
        for (n = 0; n < 8 && !got; n++) begin
            @(negedge clock);
            if (cfg_bus_ack === 1'b1) begin
                got = 1'b1;
                rd  = cfg_bus_rdata;
            end
        end
        @(negedge clock);
        // Released address and data lines show no stale value
        cfg_bus_strobe = 1'b0;
        cfg_bus_addr   = ~a;
        cfg_bus_wdata  = ~d;
    endtask
endmodule

// file: dv/pllc_top_test.sv
// Self-checking bench for the loop control and configuration port
`timescale 1ns/1ns
module pllc_top_test;
    logic       clock, srst, loop_reset, full_loop_reset, power_down_req, cfg_bus_reset;
    logic [3:0] gates, outs;
    logic [1:0] divrst;
    logic       loop_locked, phase_ctrl_source_flag, cfg_bus_ack, ack_q, g;
    logic       cfg_bus_strobe, cfg_bus_write_en;
    logic [4:0] cfg_bus_addr;
    logic [7:0] cfg_bus_wdata, cfg_bus_rdata, d;
    int         fail_count, num_checks, n;

    pllc_top u_pllc_top (
        .clock, .srst, .loop_reset, .full_loop_reset, .power_down_req,
        .out_b_divider_reset(divrst[0]), .out_c_divider_reset(divrst[1]),
        .primary_out_gate(gates[0]), .out_a_gate(gates[1]),
        .out_b_gate(gates[2]), .out_c_gate(gates[3]),
        .primary_out_clk(outs[0]), .secondary_out_clk_a(outs[1]),
        .secondary_out_clk_b(outs[2]), .secondary_out_clk_c(outs[3]),
        .loop_locked, .phase_ctrl_source_flag, .cfg_bus_reset, .cfg_bus_strobe,
        .cfg_bus_write_en, .cfg_bus_addr, .cfg_bus_wdata, .cfg_bus_rdata, .cfg_bus_ack
    );
    pllc_fabric u_pllc_fabric (
        .clock, .cfg_bus_strobe, .cfg_bus_write_en, .cfg_bus_addr,
        .cfg_bus_wdata, .cfg_bus_ack, .cfg_bus_rdata
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        u_pllc_fabric.xfer(we, a, wd, 1, rd, g);
        chk(g === 1'b1, "no acknowledge");
    endtask

    task automatic wait_lock;
        for (n = 0; n < 100 && loop_locked !== 1'b1; n++) @(negedge clock);
        chk(loop_locked === 1'b1, "loop did not lock");
    endtask

    task automatic edges(input int k, input int cyc, output int e);
        logic p;
        @(negedge clock);
        p = outs[k];
        e = 0;
        repeat (cyc) begin
            @(negedge clock);
            if (outs[k] !== p) e++;
            p = outs[k];
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults;
        logic [4:0] a [5] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h1F};
        logic [7:0] e [5] = '{pllc_pkg::RST_DIV, pllc_pkg::RST_DIV, pllc_pkg::RST_PH,
                              pllc_pkg::RST_M, pllc_pkg::RST_ZERO};
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, a[i], 8'h00, d);
            chk(d === e[i], "reset value");
        end
    endtask

    task automatic t_bus;
        xfer(1'b1, 5'h15, 8'hA5, d);
        chk(d === 8'h00, "write ack data");
        xfer(1'b1, 5'h15, 8'h5A, d);
        chk(d === 8'hA5, "old value");
        xfer(1'b0, 5'h15, 8'h00, d);
        chk(d === 8'h5A, "read back");
    endtask

    task automatic t_src;
        xfer(1'b1, pllc_pkg::REG_PH_SRC, 8'h01, d);
        chk(phase_ctrl_source_flag === 1'b1, "source bus");
        xfer(1'b1, pllc_pkg::REG_PH_SRC, 8'h00, d);
        chk(phase_ctrl_source_flag === 1'b0, "source ports");
    endtask

    task automatic t_busrst;
        cfg_bus_reset = 1'b1;
        u_pllc_fabric.xfer(1'b1, 5'h15, 8'hFF, 1, d, g);
        chk(g === 1'b0, "ack during bus reset");
        chk(cfg_bus_rdata === 8'h00, "rdata after bus reset");
        cfg_bus_reset = 1'b0;
        xfer(1'b0, 5'h15, 8'h00, d);
        chk(d === 8'h5A, "stored value lost");
    endtask

    task automatic t_lock;
        wait_lock();
        for (int k = 0; k < 3; k++) begin
            power_down_req  = (k == 0);
            loop_reset      = (k == 1);
            full_loop_reset = (k == 2);
            repeat (2) @(negedge clock);
            chk(loop_locked === 1'b0, "lock kept");
            repeat (4) @(negedge clock);
            chk(outs === 4'h0, "outputs run");
            {power_down_req, loop_reset, full_loop_reset} = 3'b000;
            wait_lock();
        end
    endtask

    task automatic t_gates;
        for (int k = 0; k < 4; k++) begin
            edges(k, 40, n);
            chk(n >= 9 && n <= 11, "output rate");
            gates[k] = 1'b0;
            edges(k, 16, n);
            chk(n == 0 && outs[k] === 1'b0, "gated output runs");
            edges((k + 1) % 4, 16, n);
            chk(n >= 3, "other output stopped");
            gates[k] = 1'b1;
        end
    endtask

    task automatic t_divrst;
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, 5'(k + 2), 8'h01, d);
            divrst[k] = 1'b1;
            edges(k + 2, 16, n);
            chk(n == 0 && outs[k + 2] === 1'b0, "divider not held");
            edges(0, 16, n);
            chk(n >= 3 && loop_locked === 1'b1, "reset too wide");
            divrst[k] = 1'b0;
            edges(k + 2, 40, n);
            chk(n >= 19 && n <= 21, "new divide");
        end
    endtask

    // ----------------------------------------
    // Clock, checks and sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (cfg_bus_ack === 1'b1 && ack_q === 1'b1)
            chk(1'b0, "ack longer than one cycle");
        ack_q <= cfg_bus_ack;
    end

    initial begin
        #500_000;
        fail_count++;
        summarize();
    end

    initial begin
        {srst, loop_reset, full_loop_reset, power_down_req, cfg_bus_reset} = 5'h10;
        gates  = 4'hF;
        divrst = 2'h0;
        repeat (16) @(negedge clock);
        chk({outs, loop_locked, cfg_bus_ack} === 6'h00, "reset outputs");
        srst = 1'b0;
        t_defaults();
        t_bus();
        t_src();
        t_busrst();
        t_lock();
        t_gates();
        t_divrst();
        summarize();
    end
endmodule
